// ---- dner_params.svh ----
`ifndef DNER_PARAMS_SVH
`define DNER_PARAMS_SVH

`define DNER_BANK_WIDTH  9
`define DNER_BANK_COUNT  2
`define DNER_CLEAR_VALUE 9'h000

`endif

// ---- dner_pkg.sv ----
`include "dner_params.svh"

package dner_pkg;

    typedef logic [`DNER_BANK_WIDTH-1:0] dner_word_t;

    // control pins of one bank, all sampled by the three-stage synchroniser
    typedef struct packed
    {
        logic bank_clock;
        logic bank_clock_enable_n;
        logic bank_clear_n;
        logic bank_output_enable_n;
    } dner_ctrl_s;

    // three-state output group of one bank
    typedef struct packed
    {
        dner_word_t bank_data_out;
        dner_word_t bank_data_oe;
    } dner_drive_s;

endpackage

// ---- dner_bank.sv ----
`timescale 1ns/100ps
`include "dner_params.svh"

module dner_bank
    import dner_pkg::*;
#(
    parameter int WIDTH = `DNER_BANK_WIDTH
)
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire dner_pkg::dner_ctrl_s ctrl,
    input  wire logic [WIDTH-1:0]  bank_data_in,
    output dner_pkg::dner_drive_s  drive
);
    import dner_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // three-flop synchronisers on pins
    dner_ctrl_s       ctrl_s1;
    dner_ctrl_s       ctrl_s2;
    dner_ctrl_s       ctrl_s3;
    dner_ctrl_s       ctrl_q;
    logic [WIDTH-1:0] data_s1;
    logic [WIDTH-1:0] data_s2;
    logic [WIDTH-1:0] data_s3;
    dner_ctrl_s       next_ctrl_q;

    // agreement filter: a change counts once stages two and three match
    function automatic logic agree(input logic a, input logic b, input logic old);
        agree = (a == b) ? b : old;
    endfunction

    always_comb
    begin
        next_ctrl_q.bank_clock           = agree(ctrl_s2.bank_clock, ctrl_s3.bank_clock, ctrl_q.bank_clock);
        next_ctrl_q.bank_clock_enable_n  = agree(ctrl_s2.bank_clock_enable_n, ctrl_s3.bank_clock_enable_n,
                                                 ctrl_q.bank_clock_enable_n);
        next_ctrl_q.bank_clear_n         = agree(ctrl_s2.bank_clear_n, ctrl_s3.bank_clear_n, ctrl_q.bank_clear_n);
        next_ctrl_q.bank_output_enable_n = agree(ctrl_s2.bank_output_enable_n, ctrl_s3.bank_output_enable_n,
                                                 ctrl_q.bank_output_enable_n);
    end

    // power-up: clock high so no false edge, clear inactive, outputs off
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_s1 <= '{1'b1, 1'b1, 1'b1, 1'b1};
            ctrl_s2 <= '{1'b1, 1'b1, 1'b1, 1'b1};
            ctrl_s3 <= '{1'b1, 1'b1, 1'b1, 1'b1};
            ctrl_q  <= '{1'b1, 1'b1, 1'b1, 1'b1};
            data_s1 <= '0;
            data_s2 <= '0;
            data_s3 <= '0;
        end
        else
        begin
            ctrl_s1 <= ctrl;
            ctrl_s2 <= ctrl_s1;
            ctrl_s3 <= ctrl_s2;
            ctrl_q  <= next_ctrl_q;
            data_s1 <= bank_data_in;
            data_s2 <= data_s1;
            data_s3 <= data_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // storage flops
    logic             clk_rise;
    logic [WIDTH-1:0] store;
    logic [WIDTH-1:0] next_store;

    // data taken from stage three, which lines up with the clock edge decision after one
    // cycle of filtering; data must be stable around the edge as on the pin
    assign clk_rise = next_ctrl_q.bank_clock && !ctrl_q.bank_clock;

    always_comb
    begin
        next_store = store;
        if (!next_ctrl_q.bank_clear_n)
            next_store = WIDTH'(`DNER_CLEAR_VALUE);
        else if (clk_rise && !next_ctrl_q.bank_clock_enable_n)
            next_store = data_s3;
        // enable high: contents held whatever the clock does
        // output enable takes no part in loading or clearing
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            store <= WIDTH'(`DNER_CLEAR_VALUE);
        else
            store <= next_store;
    end

    ////////////////////////////////////////////////////////////////////////////
    // three-state drivers
    logic [WIDTH-1:0] oe;
    logic [WIDTH-1:0] next_oe;

    always_comb
    begin
        next_oe = next_ctrl_q.bank_output_enable_n ? '0 : '1;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            oe <= '0;
        else
            oe <= next_oe;
    end

    assign drive.bank_data_out = store;
    assign drive.bank_data_oe  = oe;
endmodule

// ---- dner_top.sv ----
`timescale 1ns/100ps
`include "dner_params.svh"

// Overview of operation
// - two independent nine-bit banks; tying controls together gives one eighteen-bit register
// - enable low, clear inactive: each flop loads its input on clock rise
// - enable high, clear inactive: contents held whatever clock and data do
// - clear low forces all nine flops of the bank to zero at once
// - output enable high puts all nine bank outputs in high impedance
// - output enable gates drivers only; loading, holding, clearing unaffected
// - output enable low: each output drives its flop value
module dner_top
    import dner_pkg::*;
#(
    parameter int WIDTH = `DNER_BANK_WIDTH,
    parameter int BANKS = `DNER_BANK_COUNT
)
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic [BANKS-1:0]        bank_clock,
    input  wire logic [BANKS-1:0]        bank_clock_enable_n,
    input  wire logic [BANKS-1:0]        bank_clear_n,
    input  wire logic [BANKS-1:0]        bank_output_enable_n,
    input  wire logic [BANKS*WIDTH-1:0]  bank_data_in,
    output logic [BANKS*WIDTH-1:0]       bank_data_out,
    output logic [BANKS*WIDTH-1:0]       bank_data_oe
);
    import dner_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // one independent instance per bank
    for (genvar b = 0; b < BANKS; b++)
    begin : g_bank
        dner_ctrl_s  ctrl;
        dner_drive_s drive;

        assign ctrl = '{bank_clock[b], bank_clock_enable_n[b], bank_clear_n[b], bank_output_enable_n[b]};

        dner_bank #(.WIDTH(WIDTH)) u_bank
        (
            .sys_clk      (sys_clk),
            .rst          (rst),
            .ctrl         (ctrl),
            .bank_data_in (bank_data_in[b*WIDTH +: WIDTH]),
            .drive        (drive)
        );

        assign bank_data_out[b*WIDTH +: WIDTH] = drive.bank_data_out;
        assign bank_data_oe[b*WIDTH +: WIDTH]  = drive.bank_data_oe;
    end
endmodule

// ---- dner_props.sv ----
`timescale 1ns/100ps
module dner_props #(parameter int WIDTH = 9, parameter int BANKS = 2)
(
    input logic [0:0]             sys_clk,
    input logic [0:0]             rst,
    input logic [BANKS-1:0]       bank_clock,
    input logic [BANKS-1:0]       bank_clock_enable_n,
    input logic [BANKS-1:0]       bank_clear_n,
    input logic [BANKS-1:0]       bank_output_enable_n,
    input logic [BANKS*WIDTH-1:0] bank_data_in,
    input logic [BANKS*WIDTH-1:0] bank_data_out,
    input logic [BANKS*WIDTH-1:0] bank_data_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_reset_quiet: assert property (disable iff (1'h0) rst [*2] |-> !bank_data_oe && !bank_data_out)
        else $error("live in reset");
    chk_off_float: assert property (bank_output_enable_n[0] [*5] |-> !bank_data_oe[WIDTH-1:0])
        else $error("still driving");
    chk_on_drive: assert property (!bank_output_enable_n[0] [*5] |-> &bank_data_oe[WIDTH-1:0])
        else $error("not driving");
    chk_clear_low: assert property (!bank_clear_n[0] [*5] |-> !bank_data_out[WIDTH-1:0])
        else $error("not cleared");
    chk_clear_upper: assert property (!bank_clear_n[1] [*5] |-> !bank_data_out[2*WIDTH-1:WIDTH])
        else $error("upper not cleared");
    // eight quiet cycles leave no load in flight through the filter
    chk_hold_low: assert property ((bank_clock_enable_n[0] && bank_clear_n[0]) [*8]
        |-> $stable(bank_data_out[WIDTH-1:0])) else $error("hold broken");
    chk_load_low: assert property ($rose(bank_clock[0]) && !bank_clock_enable_n[0] ##0 bank_clear_n[0] [*5]
        |-> bank_data_out[WIDTH-1:0] == $past(bank_data_in[WIDTH-1:0], 4)) else $error("load lost");
    chk_load_upper: assert property ($rose(bank_clock[1]) && !bank_clock_enable_n[1] ##0 bank_clear_n[1] [*5]
        |-> bank_data_out[2*WIDTH-1:WIDTH] == $past(bank_data_in[2*WIDTH-1:WIDTH], 4)) else $error("upper lost");
endmodule
////////////////////////////////////////////////////////////////
bind dner_top dner_props #(.WIDTH(WIDTH), .BANKS(BANKS)) u_props (.*);

// ---- dner_bus_model.sv ----
`timescale 1ns/100ps
module dner_bus_model
(
    input logic [17:0]  bank_data_out,
    input logic [17:0]  bank_data_oe,
    output logic [17:0] bus
);
    // a released bit reads back inverted, so a float never passes for data
    assign bus = (bank_data_out & bank_data_oe) | (~bank_data_out & ~bank_data_oe);
endmodule

// ---- dual_nine_bit_enabled_register_tb.sv ----
`timescale 1ns/100ps
module dual_nine_bit_enabled_register_tb;
    logic        sys_clk = 1'h0;
    logic        rst = 1'h1;
    logic [1:0]  bank_clock = 2'h0;
    logic [1:0]  bank_clock_enable_n = 2'h3;
    logic [1:0]  bank_clear_n = 2'h3;
    logic [1:0]  bank_output_enable_n = 2'h3;
    logic [17:0] bank_data_in = 18'h0;
    wire  [17:0] bank_data_out, bank_data_oe, bus;
    int          err_total = 0;
    int          tests_run = 0;
    dner_top DUT (.*);
    dner_bus_model far_side (.*);
    initial forever #12.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////
    task automatic w(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // outputs are looked at mid-cycle, away from the edge that launches them
    task automatic settle;
        @(negedge sys_clk);
    endtask
    task automatic chk(logic [17:0] got, logic [17:0] exp);
        tests_run++;
        err_total += int'(got !== exp);
        if (got !== exp) $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    endtask
    task automatic put(logic [1:0] e, logic [1:0] c, logic [1:0] o, logic [17:0] d);
        @(posedge sys_clk);
        bank_clock_enable_n <= e;
        bank_clear_n <= c;
        bank_output_enable_n <= o;
        bank_data_in <= d;
    endtask
    // data settles two cycles before the rise, pin clock keeps 4 high and 4 low
    task automatic pulse(logic [1:0] m);
        w(2);
        bank_clock <= m;
        w(4);
        bank_clock <= 2'h0;
        w(4);
        settle;
    endtask
    task automatic t_load;
        put(2'h0, 2'h3, 2'h0, 18'h2a5c3);
        pulse(2'h3);
        chk(bus, 18'h2a5c3);
        put(2'h0, 2'h3, 2'h0, 18'h15a3c);
        pulse(2'h1);
        chk(bus, 18'h2a43c);
        put(2'h3, 2'h3, 2'h0, 18'h0);
        pulse(2'h3);
        chk(bus, 18'h2a43c);
        $display("load and hold done");
    endtask
    task automatic t_oe_clear;
        put(2'h0, 2'h3, 2'h3, 18'h3ffff);
        pulse(2'h3);
        chk(bank_data_oe, 18'h0);
        put(2'h0, 2'h1, 2'h0, 18'h3fe00);
        pulse(2'h2);
        chk(bus, 18'h001ff);
        put(2'h0, 2'h0, 2'h0, 18'h0);
        w(6);
        settle;
        chk(bus, 18'h0);
        $display("oe and clear done");
    endtask
    task automatic t_reset;
        put(2'h0, 2'h3, 2'h0, 18'h3ffff);
        pulse(2'h3);
        chk(bus, 18'h3ffff);
        @(posedge sys_clk);
        rst <= 1'h1;
        w(2);
        settle;
        chk(bank_data_oe | bank_data_out, 18'h0);
        @(posedge sys_clk);
        rst <= 1'h0;
        w(6);
        settle;
        chk(bank_data_oe, 18'h3ffff);
        chk(bus, 18'h0);
        $display("mid-run reset done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        w(8);
        rst <= 1'h0;
        w(2);
        settle;
        chk(bank_data_oe | bank_data_out, 18'h0);
        t_load;
        t_oe_clear;
        t_reset;
        wrap_up;
    end
    initial
    begin
        w(1000);
        err_total++;
        wrap_up;
    end
endmodule
